// >>> inc/fss_defs.vh
// Constants for the frequency slope protection stage
// Function
// - The stage enters its started state only after the absolute slope has stayed above the setting for 80 ms.
// - After entering the started state the start output rises only once a further 60 ms has passed.
// - At operate delay expiry the stage trips if the average slope since the start is still above the setting.
// - The stage returns to idle after 80 ms of stable slope once the operate delay has expired without a trip.
// - While started the stage does not release on slope fluctuation and keeps averaging from the start instant.
// - With the minimum delay below the operate delay, trip time is setting times operate delay over average slope.
// - In dependent timing the stage never trips sooner than the minimum delay.
// - For slope settings below 0.7 Hz/s an extra lower bound applies to the fastest operate time.
// - The stage holds four setting groups and runs from the selected one.
// - The slope setting spans 0.2 to 10.0 Hz/s in steps of 0.1 Hz/s.
// - Operate delay and minimum delay span 0.14 to 10.00 s in steps of 0.02 s.
// - The stage is blocked by the shared low-voltage block limit of the frequency stages.
// - Blocking applies while the largest line-to-line voltage lies below that limit.
`ifndef FSS_DEFS_VH
`define FSS_DEFS_VH

// Timebase
`define FSS_CLK_NS        40
`define FSS_MS_NS         1000000
`define FSS_MS_CYCLES     (`FSS_MS_NS / `FSS_CLK_NS)

// Stage timing in milliseconds
`define FSS_QUAL_MS       16'd80
`define FSS_START_MS      16'd60
`define FSS_STABLE_MS     16'd80
`define FSS_STEP_MS       16'd20
`define FSS_SENS_MIN_MS   16'd300

// Setting ranges, slope in 0.1 Hz/s, delays in 20 ms steps
`define FSS_SLOPE_SCALE   16'd10
`define FSS_SLOPE_MIN     16'd2
`define FSS_SLOPE_MAX     16'd100
`define FSS_DLY_MIN       16'd7
`define FSS_DLY_MAX       16'd500
`define FSS_SENS_LIMIT    16'd7

// Register offsets
`define FSS_CTRL_ADDR     8'h00
`define FSS_STATUS_ADDR   8'h04
`define FSS_LVB_ADDR      8'h08
`define FSS_ISTAT_ADDR    8'h0C
`define FSS_IMASK_ADDR    8'h10
`define FSS_GRP_FIRST     4'h2
`define FSS_GRP_LAST      4'h5
`define FSS_GRP_SLOPE     4'h0
`define FSS_GRP_TOP       4'h4
`define FSS_GRP_MINIMUM_OPERATE_DELAY      4'h8

// Field positions
`define FSS_CTRL_EN_BIT   0
`define FSS_CTRL_GRP_LSB  1
`define FSS_INT_START     0
`define FSS_INT_TRIP      1
`define FSS_INT_BLOCK     2

// Reset values
`define FSS_CTRL_RST      3'h0
`define FSS_LVB_RST       16'h0000
`define FSS_SLOPE_RST     16'h0005
`define FSS_DLY_RST       16'h001E
`define FSS_IMASK_RST     3'h0

`endif

// >>> rtl/fss_tick.v
// Millisecond enable pulse divider
`timescale 1ns/100ps
module fss_tick #(
    parameter DIV = 25000
) (
    input  wire i_clock,
    input  wire i_rst,
    output reg  o_tick
);
    reg [15:0] cnt_reg;

    // Count up and pulse once per period
    always @(posedge i_clock) begin
        if (i_rst) begin
            cnt_reg <= 16'h0000;
            o_tick  <= 1'b0;
        end else if (cnt_reg == DIV[15:0] - 16'h0001) begin
            cnt_reg <= 16'h0000;
            o_tick  <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 16'h0001;
            o_tick  <= 1'b0;
        end
    end
endmodule // fss_tick

// >>> rtl/fss_stage.v
// Frequency slope protection stage with register port
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/100ps
`include "fss_defs.vh"
module fss_stage #(
    parameter MS_CYCLES = `FSS_MS_CYCLES
) (
    input  wire        i_clock,
    input  wire        i_rst,
    input  wire [7:0]  i_addr,
    input  wire [31:0] i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    output reg  [31:0] o_rdata,
    input  wire [15:0] i_slope_abs,
    input  wire [15:0] i_u12,
    input  wire [15:0] i_u23,
    input  wire [15:0] i_u31,
    output reg         o_start,
    output reg         o_trip,
    output wire        o_irq
);
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_QUAL = 2'h1;
    localparam [1:0] ST_RUN  = 2'h2;
    localparam [1:0] ST_TRIP = 2'h3;

    // Clamp a setting into its range
    function [15:0] clamp;
        input [15:0] v;
        input [15:0] lo;
        input [15:0] hi;
        begin
            if (v < lo) begin
                clamp = lo;
            end else if (v > hi) begin
                clamp = hi;
            end else begin
                clamp = v;
            end
        end
    endfunction

    // Larger of two values
    function [15:0] max2;
        input [15:0] a;
        input [15:0] b;
        begin
            max2 = (a > b) ? a : b;
        end
    endfunction

    reg  [2:0]  ctrl_reg;
    reg  [15:0] lvb_reg;
    reg  [2:0]  istat_reg;
    reg  [2:0]  imask_reg;
    reg  [15:0] slope_set_reg [0:3];
    reg  [15:0] top_set_reg   [0:3];
    reg  [15:0] minimum_operate_delay_set_reg  [0:3];
    reg  [1:0]  state_reg;
    reg  [15:0] qual_reg;
    reg  [15:0] n_reg;
    reg  [31:0] sum_reg;
    reg  [15:0] stable_reg;
    reg         blocked_reg;
    reg  [2:0]  prev_reg;
    wire        tick;
    wire        en;
    wire [1:0]  grp;
    wire [3:0]  page;
    wire [3:0]  page_off;
    wire [1:0]  widx;
    wire        grp_hit;
    wire [15:0] vmax;
    wire [15:0] set10;
    wire [15:0] top_ms;
    wire [15:0] minimum_operate_delay_ms;
    wire [15:0] floor_ms;
    wire        above;
    wire [15:0] n_inc;
    wire [31:0] sum_inc;
    wire [15:0] stable_inc;
    wire [31:0] need_avg;
    wire [31:0] need_dep;
    wire        floor_ok;
    wire        avg_ok;
    wire        law_ok;
    wire        trip_ok;
    wire        idle_ok;
    wire [4:0]  status;
    wire [2:0]  events;
    wire [2:0]  istat_next;
    integer     i;

    fss_tick #(
        .DIV (MS_CYCLES)
    ) u_tick (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .o_tick  (tick)
    );

    // Selected group settings in working units
    assign en       = ctrl_reg[`FSS_CTRL_EN_BIT];
    assign grp      = ctrl_reg[`FSS_CTRL_GRP_LSB +: 2];
    assign set10    = slope_set_reg[grp] * `FSS_SLOPE_SCALE;
    assign top_ms   = top_set_reg[grp] * `FSS_STEP_MS;
    assign minimum_operate_delay_ms  = minimum_operate_delay_set_reg[grp] * `FSS_STEP_MS;
    assign floor_ms = (slope_set_reg[grp] < `FSS_SENS_LIMIT)
                      ? max2(minimum_operate_delay_ms, `FSS_SENS_MIN_MS) : minimum_operate_delay_ms;

    // Address decode helpers for group pages
    assign page     = i_addr[7:4];
    assign page_off = page - `FSS_GRP_FIRST;
    assign widx     = page_off[1:0];                                   // Pages 2 to 5 give groups 0 to 3
    assign grp_hit  = (page >= `FSS_GRP_FIRST) && (page <= `FSS_GRP_LAST);

    // Largest line-to-line voltage
    assign vmax = max2(max2(i_u12, i_u23), i_u31);

    // Slope comparison, reset ratio one
    assign above = i_slope_abs > set10;

    // Next values of the running average terms
    assign n_inc      = n_reg + 16'h0001;
    assign sum_inc    = sum_reg + {16'h0000, i_slope_abs};
    assign stable_inc = above ? 16'h0000 : stable_reg + 16'h0001;
    assign need_avg   = {16'h0000, set10} * {16'h0000, n_inc};
    assign need_dep   = {16'h0000, set10} * {16'h0000, top_ms};

    // Trip terms: time floor, average above setting, time law
    assign floor_ok = n_inc >= floor_ms;
    assign avg_ok   = sum_inc > need_avg;
    assign law_ok   = (sum_inc >= need_dep) || (n_inc >= top_ms);

    // Trip when all terms hold; idle after the delay and a quiet slope
    assign trip_ok = floor_ok && avg_ok && law_ok;
    assign idle_ok = (n_inc >= top_ms) && (stable_inc >= `FSS_STABLE_MS);

    // Status word: blocked, trip, start, state
    assign status = {blocked_reg, o_trip, o_start, state_reg};

    // Register writes with range clamping
    always @(posedge i_clock) begin
        if (i_rst) begin
            ctrl_reg  <= `FSS_CTRL_RST;
            lvb_reg   <= `FSS_LVB_RST;
            imask_reg <= `FSS_IMASK_RST;
            for (i = 0; i < 4; i = i + 1) begin
                slope_set_reg[i] <= `FSS_SLOPE_RST;
                top_set_reg[i]   <= `FSS_DLY_RST;
                minimum_operate_delay_set_reg[i]  <= `FSS_DLY_RST;
            end
        end else if (i_wr) begin
            if (i_addr == `FSS_CTRL_ADDR) begin
                ctrl_reg <= i_wdata[2:0];
            end else if (i_addr == `FSS_LVB_ADDR) begin
                lvb_reg <= i_wdata[15:0];
            end else if (i_addr == `FSS_IMASK_ADDR) begin
                imask_reg <= i_wdata[2:0];
            end else if (grp_hit && i_addr[3:0] == `FSS_GRP_SLOPE) begin
                slope_set_reg[widx] <= clamp(i_wdata[15:0], `FSS_SLOPE_MIN, `FSS_SLOPE_MAX);
            end else if (grp_hit && i_addr[3:0] == `FSS_GRP_TOP) begin
                top_set_reg[widx] <= clamp(i_wdata[15:0], `FSS_DLY_MIN, `FSS_DLY_MAX);
            end else if (grp_hit && i_addr[3:0] == `FSS_GRP_MINIMUM_OPERATE_DELAY) begin
                minimum_operate_delay_set_reg[widx] <= clamp(i_wdata[15:0], `FSS_DLY_MIN, `FSS_DLY_MAX);
            end
        end
    end

    // Read data one cycle after the strobe
    always @(posedge i_clock) begin
        if (i_rst) begin
            o_rdata <= 32'h00000000;
        end else if (i_rd) begin
            if (i_addr == `FSS_CTRL_ADDR) begin
                o_rdata <= {29'h00000000, ctrl_reg};
            end else if (i_addr == `FSS_STATUS_ADDR) begin
                o_rdata <= {27'h0000000, status};
            end else if (i_addr == `FSS_LVB_ADDR) begin
                o_rdata <= {16'h0000, lvb_reg};
            end else if (i_addr == `FSS_ISTAT_ADDR) begin
                o_rdata <= {29'h00000000, istat_reg};
            end else if (i_addr == `FSS_IMASK_ADDR) begin
                o_rdata <= {29'h00000000, imask_reg};
            end else if (grp_hit && i_addr[3:0] == `FSS_GRP_SLOPE) begin
                o_rdata <= {16'h0000, slope_set_reg[widx]};
            end else if (grp_hit && i_addr[3:0] == `FSS_GRP_TOP) begin
                o_rdata <= {16'h0000, top_set_reg[widx]};
            end else if (grp_hit && i_addr[3:0] == `FSS_GRP_MINIMUM_OPERATE_DELAY) begin
                o_rdata <= {16'h0000, minimum_operate_delay_set_reg[widx]};
            end else begin
                o_rdata <= 32'h00000000;
            end
        end else begin
            o_rdata <= 32'h00000000;
        end
    end

    // Shared low-voltage block
    always @(posedge i_clock) begin
        if (i_rst) begin
            blocked_reg <= 1'b0;
        end else begin
            blocked_reg <= vmax < lvb_reg;
        end
    end

    // Stage sequence, advanced on the millisecond tick
    always @(posedge i_clock) begin
        if (i_rst) begin
            state_reg  <= ST_IDLE;
            qual_reg   <= 16'h0000;
            n_reg      <= 16'h0000;
            sum_reg    <= 32'h00000000;
            stable_reg <= 16'h0000;
            o_start    <= 1'b0;
            o_trip     <= 1'b0;
        end else if (blocked_reg || !en) begin
            state_reg  <= ST_IDLE;
            qual_reg   <= 16'h0000;
            n_reg      <= 16'h0000;
            sum_reg    <= 32'h00000000;
            stable_reg <= 16'h0000;
            o_start    <= 1'b0;
            o_trip     <= 1'b0;
        end else if (tick) begin
            case (state_reg)
                ST_IDLE: begin
                    if (above) begin
                        state_reg <= ST_QUAL;
                        qual_reg  <= 16'h0001;
                    end
                end
                ST_QUAL: begin
                    if (!above) begin
                        state_reg <= ST_IDLE;
                        qual_reg  <= 16'h0000;
                    end else if (qual_reg + 16'h0001 >= `FSS_QUAL_MS) begin
                        state_reg  <= ST_RUN;
                        qual_reg   <= 16'h0000;
                        n_reg      <= 16'h0000;
                        sum_reg    <= 32'h00000000;
                        stable_reg <= 16'h0000;
                    end else begin
                        qual_reg <= qual_reg + 16'h0001;
                    end
                end
                ST_RUN: begin
                    // Keep averaging whatever the instantaneous slope does
                    n_reg      <= n_inc;
                    sum_reg    <= sum_inc;
                    stable_reg <= stable_inc;
                    if (n_inc >= `FSS_START_MS) begin
                        o_start <= 1'b1;
                    end
                    if (trip_ok) begin
                        state_reg <= ST_TRIP;
                        o_trip    <= 1'b1;
                    end else if (idle_ok) begin
                        state_reg  <= ST_IDLE;
                        n_reg      <= 16'h0000;
                        sum_reg    <= 32'h00000000;
                        stable_reg <= 16'h0000;
                        o_start    <= 1'b0;
                    end
                end
                default: begin
                    // Tripped: hold until the slope settles
                    stable_reg <= stable_inc;
                    if (stable_inc >= `FSS_STABLE_MS) begin
                        state_reg  <= ST_IDLE;
                        n_reg      <= 16'h0000;
                        sum_reg    <= 32'h00000000;
                        stable_reg <= 16'h0000;
                        o_start    <= 1'b0;
                        o_trip     <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Rising edges of start, trip and block as events
    assign events[`FSS_INT_START] = o_start & ~prev_reg[`FSS_INT_START];
    assign events[`FSS_INT_TRIP]  = o_trip & ~prev_reg[`FSS_INT_TRIP];
    assign events[`FSS_INT_BLOCK] = blocked_reg & ~prev_reg[`FSS_INT_BLOCK];

    // Sticky status, cleared by reading it; new event wins
    assign istat_next = ((i_rd && i_addr == `FSS_ISTAT_ADDR) ? 3'h0 : istat_reg) | events;

    always @(posedge i_clock) begin
        if (i_rst) begin
            prev_reg  <= 3'h0;
            istat_reg <= 3'h0;
        end else begin
            prev_reg  <= {blocked_reg, o_trip, o_start};
            istat_reg <= istat_next;
        end
    end

    // Level interrupt from unmasked status
    assign o_irq = |(istat_reg & imask_reg);
endmodule // fss_stage

// >>> verif/fss_stage_properties.sv
// Port checks for the frequency slope stage
`timescale 1ns/100ps
module fss_stage_check #(
    parameter MS_CYCLES = 25000
) (
    input wire        i_clock,
    input wire        i_rst,
    input wire        i_wr,
    input wire        i_rd,
    input wire [31:0] o_rdata,
    input wire        o_start,
    input wire        o_trip
);
    reg [31:0] low_cnt_reg;
    reg [31:0] run_cnt_reg;

    // Cycles spent with start low, and with start high
    always @(posedge i_clock) begin
        if (i_rst || o_start)
            low_cnt_reg <= 32'h0;
        else
            low_cnt_reg <= low_cnt_reg + 32'h1;
        if (i_rst || !o_start)
            run_cnt_reg <= 32'h0;
        else
            run_cnt_reg <= run_cnt_reg + 32'h1;
    end

    a_rdata_idle_zero: assert property (@(posedge i_clock) disable iff (i_rst)
        !$past(i_rd) |-> o_rdata == 32'h0) else $error("read data outside read slot");
    a_rdata_after_wr: assert property (@(posedge i_clock) disable iff (i_rst)
        i_wr |=> o_rdata == 32'h0) else $error("read data after a write");
    a_start_qualified: assert property (@(posedge i_clock) disable iff (i_rst)
        $rose(o_start) |-> low_cnt_reg >= 139 * MS_CYCLES) else $error("start too early");
    a_trip_min_gap: assert property (@(posedge i_clock) disable iff (i_rst)
        $rose(o_trip) |-> run_cnt_reg >= 79 * MS_CYCLES) else $error("trip too soon after start");
    a_trip_needs_start: assert property (@(posedge i_clock) disable iff (i_rst)
        o_trip |-> o_start) else $error("trip without start");
    a_trip_start_held: assert property (@(posedge i_clock) disable iff (i_rst)
        $rose(o_trip) |-> $past(o_start, 2)) else $error("trip rose with fresh start");
    a_start_fall_both: assert property (@(posedge i_clock) disable iff (i_rst)
        $fell(o_start) |-> !o_trip) else $error("trip kept after start fell");
    a_trip_fall_both: assert property (@(posedge i_clock) disable iff (i_rst)
        $fell(o_trip) |-> !o_start) else $error("start kept after trip fell");
endmodule // fss_stage_check

bind fss_stage fss_stage_check #(.MS_CYCLES(MS_CYCLES)) u_chk (.i_clock(i_clock), .i_rst(i_rst),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_start(o_start), .o_trip(o_trip));

// >>> verif/fss_meas_model.sv
// Behavioural measurement front end: slope and line voltages
`timescale 1ns/100ps
module fss_meas_model #(
    parameter MS_CYCLES = 4
) (
    input  wire        i_clock,
    input  wire        i_rst,
    input  wire        i_fluct,
    input  wire [15:0] i_level,
    input  wire [15:0] i_volt,
    input  wire [1:0]  i_sel,
    output wire [15:0] o_slope,
    output wire [15:0] o_u12,
    output wire [15:0] o_u23,
    output wire [15:0] o_u31
);
    reg [15:0] div_reg;
    reg        phase_reg;

    // Millisecond phase for the fluctuating slope
    always @(posedge i_clock) begin
        if (i_rst || div_reg == MS_CYCLES - 1)
            div_reg <= 16'h0000;
        else
            div_reg <= div_reg + 16'h0001;
        if (i_rst)
            phase_reg <= 1'b0;
        else if (div_reg == MS_CYCLES - 1)
            phase_reg <= ~phase_reg;
    end

    // Slope alternates level and zero each ms when fluctuating
    assign o_slope = (i_fluct && phase_reg) ? 16'h0000 : i_level;
    // Selected line carries the full voltage, the others a quarter
    assign o_u12 = (i_sel == 2'd0) ? i_volt : (i_volt >> 2);
    assign o_u23 = (i_sel == 2'd1) ? i_volt : (i_volt >> 2);
    assign o_u31 = (i_sel == 2'd2) ? i_volt : (i_volt >> 2);
endmodule // fss_meas_model

// >>> verif/tb_top.sv
// Self-checking bench for the frequency slope stage
`timescale 1ns/100ps
module tb_top;
    localparam MS = 4;
    localparam LIM = 2000;
    reg          i_clock = 1'b0;
    reg          i_rst = 1'b1;
    reg  [7:0]   i_addr = 8'h00;
    reg  [31:0]  i_wdata = 32'h0;
    reg          i_wr = 1'b0;
    reg          i_rd = 1'b0;
    reg          fluct = 1'b0;
    reg  [15:0]  level = 16'h0000;
    reg  [15:0]  volt = 16'h00C8;
    reg  [1:0]   sel = 2'd0;
    reg          rd_d = 1'b0;
    wire [31:0]  o_rdata;
    wire [15:0]  slope, u12, u23, u31;
    wire         o_start, o_trip, o_irq;
    int          err_count = 0;
    int          compares = 0;
    int          cyc_count = 0;
    int          c, k;
    logic [31:0] exp_q[$];
    logic [7:0]  ca[6] = '{8'h50, 8'h50, 8'h50, 8'h54, 8'h54, 8'h58};
    logic [15:0] cw[6] = '{16'h0001, 16'h0065, 16'h0002, 16'h0006, 16'h01F5, 16'h0007};
    logic [15:0] ce[6] = '{16'h0002, 16'h0064, 16'h0002, 16'h0007, 16'h01F4, 16'h0007};

    fss_stage #(.MS_CYCLES(MS)) uut (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_slope_abs(slope),
        .i_u12(u12), .i_u23(u23), .i_u31(u31), .o_start(o_start), .o_trip(o_trip), .o_irq(o_irq));
    fss_meas_model #(.MS_CYCLES(MS)) u_meas (.i_clock(i_clock), .i_rst(i_rst), .i_fluct(fluct),
        .i_level(level), .i_volt(volt), .i_sel(sel), .o_slope(slope), .o_u12(u12), .o_u23(u23),
        .o_u31(u31));

    initial forever #20 i_clock = ~i_clock;

    task results;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One bus cycle; a read notes its expected data
    task bus(input bit w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_wr <= w;
        i_rd <= !w;
        i_addr <= a;
        i_wdata <= d;
        if (!w)
            exp_q.push_back(d);
        @(posedge i_clock);
        i_wr <= 1'b0;
        i_rd <= 1'b0;
    endtask

    // Edges until start or trip reaches a level, bounded
    task wait_out(input bit trip, input bit lvl, output int n);
        n = 0;
        while (((trip ? o_trip : o_start) !== lvl) && n < LIM) begin
            @(posedge i_clock);
            #1;
            n++;
        end
        check("output wait", n < LIM, 32'h1);
    endtask

    // Read data watcher and cycle ceiling
    always @(posedge i_clock) begin
        cyc_count <= cyc_count + 1;
        rd_d <= i_rd;
        if (rd_d)
            check("rdata", o_rdata, exp_q.pop_front());
        if (cyc_count == 12000) begin
            err_count++;
            results();
        end
    end

    initial begin
        k = $urandom(29663);
        repeat (10) @(posedge i_clock);
        i_rst <= 1'b0;
        // Reset values in every group, read-only and unmapped places
        for (k = 0; k < 4; k++) begin
            bus(0, 8'h20 + 8'(k << 4), 32'h5);
            bus(0, 8'h24 + 8'(k << 4), 32'h1E);
            bus(0, 8'h28 + 8'(k << 4), 32'h1E);
        end
        bus(1, 8'h04, 32'hFF);
        bus(0, 8'h04, 32'h0);
        bus(1, 8'h14, 32'hFFFF);
        bus(0, 8'h14, 32'h0);
        bus(0, 8'h00, 32'h0);
        // Setting limits clamp
        for (k = 0; k < 6; k++) begin
            bus(1, ca[k], {16'h0, cw[k]});
            bus(0, ca[k], {16'h0, ce[k]});
        end
        // Definite time with a sensitive setting, fluctuating slope
        bus(1, 8'h24, 32'h7);
        bus(1, 8'h28, 32'h7);
        bus(1, 8'h08, 32'h64);
        bus(1, 8'h10, 32'h3);
        @(posedge i_clock);
        sel <= 2'($urandom % 3);
        level <= 16'(110 + $urandom % 90);
        bus(1, 8'h00, 32'h1);
        wait_out(0, 1, c);
        @(posedge i_clock);
        fluct <= 1'b1;
        wait_out(1, 1, c);
        check("definite delay", (c + 1 >= 240 * MS - 1) && (c + 1 <= 240 * MS + 1), 32'h1);
        check("irq", o_irq, 32'h1);
        bus(0, 8'h04, 32'h0F);
        bus(0, 8'h0C, 32'h3);
        @(negedge i_clock);
        check("irq clear", o_irq, 32'h0);
        @(posedge i_clock);
        fluct <= 1'b0;
        level <= 16'h0000;
        wait_out(1, 0, c);
        check("idle return", (c >= 78 * MS) && (c <= 81 * MS + 2), 32'h1);
        check("idle start", o_start, 32'h0);
        // Dependent timing in group one, slope and floor cases
        bus(1, 8'h30, 32'hA);
        bus(1, 8'h34, 32'h19);
        bus(1, 8'h38, 32'h7);
        for (k = 0; k < 2; k++) begin
            @(posedge i_clock);
            level <= k ? 16'h03E8 : 16'h00C8;
            bus(1, 8'h00, 32'h3);
            wait_out(0, 1, c);
            wait_out(1, 1, c);
            c = c - (k ? 80 : 190) * MS;
            check("dependent delay", (c >= -1) && (c <= 1), 32'h1);
            bus(1, 8'h00, 32'h0);
            // Enable drops at the write edge, outputs one clock later
            @(posedge i_clock);
            @(negedge i_clock);
            check("disable start", o_start, 32'h0);
            check("disable trip", o_trip, 32'h0);
        end
        // Low voltage block and release on one line
        bus(1, 8'h00, 32'h3);
        wait_out(0, 1, c);
        @(posedge i_clock);
        volt <= 16'h0032;
        repeat (3) @(negedge i_clock);
        check("blocked start", o_start, 32'h0);
        bus(0, 8'h04, 32'h10);
        @(posedge i_clock);
        volt <= 16'h00C8;
        sel <= 2'($urandom % 3);
        wait_out(0, 1, c);
        check("requalify", (c >= 139 * MS) && (c <= 141 * MS + 2), 32'h1);
        bus(0, 8'h0C, 32'h7);
        // Let the watcher compare the last read before the verdict
        repeat (2) @(posedge i_clock);
        results();
    end
endmodule // tb_top
